// ### rtl/tpd_pkg.sv
package tpd_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_DETECT_FLAGS         = 8'h12;
   localparam logic [7:0] ADDR_CH0_SENSE_CONFIG     = 8'h40;
   localparam logic [7:0] ADDR_CH1_SENSE_CONFIG     = 8'h41;
   localparam logic [7:0] ADDR_SHARED_SENSE_CONFIG  = 8'h42;
   localparam logic [7:0] ADDR_CH0_TUNING_CONFIG    = 8'h43;
   localparam logic [7:0] ADDR_CH1_TUNING_CONFIG    = 8'h44;
   localparam logic [7:0] ADDR_SHARED_EXTRA_CONFIG  = 8'h45;
   localparam logic [7:0] ADDR_CH0_NEAR_THRESHOLD   = 8'h50;
   localparam logic [7:0] ADDR_CH0_CONTACT_THRESHOLD = 8'h51;
   localparam logic [7:0] ADDR_CH1_NEAR_THRESHOLD   = 8'h52;
   localparam logic [7:0] ADDR_CH1_CONTACT_THRESHOLD = 8'h53;

   // ==========================================================
   // Field layout
   localparam int NUM_CH          = 2;
   localparam int CFG_ENABLE_BIT  = 0;
   localparam int CFG_MODE_BIT    = 1;
   localparam int FLAG_NEAR_LSB   = 0;
   localparam int FLAG_TOUCH_LSB  = 4;
   localparam int COUNT_W         = 16;
   localparam int FRAC_SHIFT      = 8;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_CONFIG    = 8'h01;
   localparam logic [7:0] RST_SHARED    = 8'h00;
   localparam logic [7:0] RST_TUNING    = 8'h00;
   localparam logic [7:0] RST_NEAR_THR  = 8'h10;
   localparam logic [7:0] RST_TOUCH_THR = 8'h40;
   localparam logic [7:0] THR_MIN       = 8'h01;

   typedef logic [7:0] tpd_byte_t;

   typedef struct packed {
      logic [COUNT_W-1:0] count;
      logic [COUNT_W-1:0] baseline_average;
   } tpd_sample_s;

   typedef struct packed {
      tpd_byte_t sense_config;
      tpd_byte_t tuning_config;
      tpd_byte_t near_threshold;
      tpd_byte_t contact_threshold;
   } tpd_chan_regs_s;

   typedef struct packed {
      tpd_chan_regs_s [NUM_CH-1:0] chan;
      tpd_byte_t                   shared_sense_config;
      tpd_byte_t                   shared_extra_config;
      tpd_byte_t                   detect_flags;
      tpd_byte_t                   rdata;
      logic                        rvalid;
      logic                        ready;
   } tpd_state_s;

endpackage : tpd_pkg

// ### rtl/tpd_detect.sv
`timescale 1ns/1ps
`default_nettype none

module tpd_detect (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rstn,
   // Register port
   input  wire logic [7:0]          reg_addr,
   input  wire logic                reg_wr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_rd,
   output logic      [7:0]          reg_rdata,
   output logic                     reg_rvalid,
   // Measurement results from the front end
   input  wire tpd_pkg::tpd_sample_s [tpd_pkg::NUM_CH-1:0] sample,
   input  wire logic                sample_valid,
   // Ready pin, open drain
   output logic                     ready_n_o,
   output logic                     ready_n_oe
);

   // ==========================================================
   // State
   tpd_pkg::tpd_state_s state_q;
   tpd_pkg::tpd_state_s state_d;

   logic [tpd_pkg::NUM_CH-1:0] near_hit;
   logic [tpd_pkg::NUM_CH-1:0] touch_hit;

   // ==========================================================
   // Per-channel detection
   genvar gi;
   generate
      for (gi = 0; gi < tpd_pkg::NUM_CH; gi++) begin : g_chan
         logic [tpd_pkg::COUNT_W-1:0]   dev;
         logic [tpd_pkg::COUNT_W+7:0]   prod;
         logic [tpd_pkg::COUNT_W-1:0]   touch_lvl;
         tpd_pkg::tpd_byte_t            near_thr;
         tpd_pkg::tpd_byte_t            touch_x;
         logic                          inductive;
         logic                          active;
         // A zero threshold would fire on any noise, so it acts as the floor value.
         assign near_thr  = (state_q.chan[gi].near_threshold == 8'h00) ?
                            tpd_pkg::THR_MIN : state_q.chan[gi].near_threshold;
         assign touch_x   = (state_q.chan[gi].contact_threshold == 8'h00) ?
                            tpd_pkg::THR_MIN : state_q.chan[gi].contact_threshold;
         assign dev       = (sample[gi].count >= sample[gi].baseline_average) ?
                            sample[gi].count - sample[gi].baseline_average :
                            sample[gi].baseline_average - sample[gi].count;
         assign prod      = {16'h0000, touch_x} * {8'h00, sample[gi].baseline_average};
         assign touch_lvl = prod[tpd_pkg::COUNT_W+7:tpd_pkg::FRAC_SHIFT];
         assign inductive = state_q.chan[gi].sense_config[tpd_pkg::CFG_MODE_BIT];
         assign active    = inductive ||
                            state_q.chan[gi].sense_config[tpd_pkg::CFG_ENABLE_BIT];
         assign near_hit[gi]  = active && (dev > {8'h00, near_thr});
         assign touch_hit[gi] = active && (dev > touch_lvl);
      end
   endgenerate

   // ==========================================================
   // Next state
   always_comb begin
      state_d        = state_q;
      state_d.rvalid = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            tpd_pkg::ADDR_CH0_SENSE_CONFIG:      state_d.chan[0].sense_config = reg_wdata;
            tpd_pkg::ADDR_CH1_SENSE_CONFIG:      state_d.chan[1].sense_config = reg_wdata;
            tpd_pkg::ADDR_SHARED_SENSE_CONFIG:   state_d.shared_sense_config = reg_wdata;
            tpd_pkg::ADDR_SHARED_EXTRA_CONFIG:   state_d.shared_extra_config = reg_wdata;
            tpd_pkg::ADDR_CH0_TUNING_CONFIG:     state_d.chan[0].tuning_config = reg_wdata;
            tpd_pkg::ADDR_CH1_TUNING_CONFIG:     state_d.chan[1].tuning_config = reg_wdata;
            tpd_pkg::ADDR_CH0_NEAR_THRESHOLD:    state_d.chan[0].near_threshold = reg_wdata;
            tpd_pkg::ADDR_CH1_NEAR_THRESHOLD:    state_d.chan[1].near_threshold = reg_wdata;
            tpd_pkg::ADDR_CH0_CONTACT_THRESHOLD: state_d.chan[0].contact_threshold = reg_wdata;
            tpd_pkg::ADDR_CH1_CONTACT_THRESHOLD: state_d.chan[1].contact_threshold = reg_wdata;
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         state_d.rvalid = 1'b1;
         case (reg_addr)
            tpd_pkg::ADDR_DETECT_FLAGS: begin
               state_d.rdata = state_q.detect_flags;
               state_d.ready = 1'b0;
            end
            tpd_pkg::ADDR_CH0_SENSE_CONFIG:      state_d.rdata = state_q.chan[0].sense_config;
            tpd_pkg::ADDR_CH1_SENSE_CONFIG:      state_d.rdata = state_q.chan[1].sense_config;
            tpd_pkg::ADDR_SHARED_SENSE_CONFIG:   state_d.rdata = state_q.shared_sense_config;
            tpd_pkg::ADDR_CH0_TUNING_CONFIG:     state_d.rdata = state_q.chan[0].tuning_config;
            tpd_pkg::ADDR_CH1_TUNING_CONFIG:     state_d.rdata = state_q.chan[1].tuning_config;
            tpd_pkg::ADDR_SHARED_EXTRA_CONFIG:   state_d.rdata = state_q.shared_extra_config;
            tpd_pkg::ADDR_CH0_NEAR_THRESHOLD:    state_d.rdata = state_q.chan[0].near_threshold;
            tpd_pkg::ADDR_CH0_CONTACT_THRESHOLD: state_d.rdata = state_q.chan[0].contact_threshold;
            tpd_pkg::ADDR_CH1_NEAR_THRESHOLD:    state_d.rdata = state_q.chan[1].near_threshold;
            tpd_pkg::ADDR_CH1_CONTACT_THRESHOLD: state_d.rdata = state_q.chan[1].contact_threshold;
            default:                             state_d.rdata = 8'h00;
         endcase
      end
      // A new result wins over the clear done by a flag read in the same cycle.
      if (sample_valid) begin
         state_d.detect_flags = 8'h00;
         state_d.detect_flags[tpd_pkg::FLAG_NEAR_LSB +: tpd_pkg::NUM_CH]  = near_hit;
         state_d.detect_flags[tpd_pkg::FLAG_TOUCH_LSB +: tpd_pkg::NUM_CH] = touch_hit;
         state_d.ready = 1'b1;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         for (int i = 0; i < tpd_pkg::NUM_CH; i++) begin
            state_q.chan[i].sense_config      <= tpd_pkg::RST_CONFIG;
            state_q.chan[i].tuning_config     <= tpd_pkg::RST_TUNING;
            state_q.chan[i].near_threshold    <= tpd_pkg::RST_NEAR_THR;
            state_q.chan[i].contact_threshold <= tpd_pkg::RST_TOUCH_THR;
         end
         state_q.shared_sense_config <= tpd_pkg::RST_SHARED;
         state_q.shared_extra_config <= tpd_pkg::RST_SHARED;
         state_q.detect_flags        <= 8'h00;
         state_q.rdata               <= 8'h00;
         state_q.rvalid              <= 1'b0;
         state_q.ready               <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata  = state_q.rdata;
   assign reg_rvalid = state_q.rvalid;
   assign ready_n_o  = 1'b0;
   assign ready_n_oe = state_q.ready;

endmodule : tpd_detect

`default_nettype wire

// ### tb/tpd_detect_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
module tpd_detect_checker (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rstn,
   // Observed ports
   input wire logic [7:0] reg_addr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   input wire logic       sample_valid,
   input wire logic       ready_n_o,
   input wire logic       ready_n_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_flag_read;
      reg_rd && reg_addr == 8'h12;
   endsequence
   AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   AST_NO_STRAY: assert property (!reg_rd |=> !reg_rvalid)
      else $error("answer without read");
   AST_RDATA_HOLDS: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
   AST_FLAG_LAYOUT: assert property (s_flag_read |=> (reg_rdata & 8'hCC) == 8'h00)
      else $error("unused flag bit set");
   AST_READY_SET: assert property (sample_valid |=> ready_n_oe)
      else $error("ready not raised");
   AST_READY_CLEAR: assert property (s_flag_read ##0 !sample_valid |=> !ready_n_oe)
      else $error("ready not cleared");
   AST_READY_HOLDS: assert property (ready_n_oe && !sample_valid && !(reg_rd
      && reg_addr == 8'h12) |=> ready_n_oe)
      else $error("ready dropped early");
   AST_READY_CAUSE: assert property ($rose(ready_n_oe) |-> $past(sample_valid))
      else $error("ready without sample");
   AST_PIN_LOW: assert property (ready_n_o == 1'b0)
      else $error("ready pin not low");
endmodule : tpd_detect_checker
bind tpd_detect tpd_detect_checker u_chk (.clk_sys, .rstn, .reg_addr, .reg_rd,
   .reg_rdata, .reg_rvalid, .sample_valid, .ready_n_o, .ready_n_oe);
`default_nettype wire

// ### tb/tpd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host side of the register port
module tpd_host_model (
   // Clock
   input wire logic  clk_sys,
   // Register port
   output logic [7:0] reg_addr,
   output logic       reg_wr,
   output logic [7:0] reg_wdata,
   output logic       reg_rd
);
   initial begin
      {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
   end
   // Idle data is inverted so a stale byte is never mistaken for a write.
   task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = w ? d : ~reg_wdata;
   endtask : acc
endmodule : tpd_host_model
`default_nettype wire

// ### tb/test_dual_channel_touch_prox_detect.sv
`timescale 1ns/1ps
`default_nettype none
module test_dual_channel_touch_prox_detect;
   logic clk_sys, rstn, sample_valid, reg_wr, reg_rd, reg_rvalid, ready_n_o, ready_n_oe;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, nt, tx, sh [0:255];
   logic [15:0] bs [2], ad, m, exp_q [$];
   logic [23:0] tt;
   tpd_pkg::tpd_sample_s [1:0] sample;
   int mismatches, tests_run, seed, i, c, t;
   logic [7:0] regs [11] = '{8'h12, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
                            8'h50, 8'h51, 8'h52, 8'h53};
   tpd_detect u_dut (.clk_sys, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata, .reg_rvalid, .sample, .sample_valid, .ready_n_o, .ready_n_oe);
   tpd_host_model u_host (.clk_sys, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
   // ==========================================================
   // Helpers
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task w(input logic [7:0] a, input logic [7:0] d);
      u_host.acc(1'b1, 1'b0, a, d);
      if (a inside {[8'h40:8'h45], [8'h50:8'h53]}) sh[a] = d;
   endtask : w
   task r(input logic [7:0] a);
      u_host.acc(1'b0, 1'b1, a, 8'h00);
      exp_q.push_back({a, sh[a]});
   endtask : r
   task sense;
      u_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
      sample_valid = 1'b1;
      sh[8'h12] = 8'h00;
      for (c = 0; c < 2; c++) begin
         sample[c].baseline_average = bs[c];
         sample[c].count = i[0] ? bs[c] + ad : bs[c] - ad;
         nt = (sh[8'h50 + 2 * c] == 8'h00) ? 8'h01 : sh[8'h50 + 2 * c];
         tx = (sh[8'h51 + 2 * c] == 8'h00) ? 8'h01 : sh[8'h51 + 2 * c];
         tt = ({16'h0, tx} * {8'h0, bs[c]}) >> 8;
         if (sh[8'h40 + c][1] | sh[8'h40 + c][0]) begin
            sh[8'h12][c] = ad > {8'h00, nt};
            sh[8'h12][4 + c] = {8'h00, ad} > tt;
         end
      end
      u_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
      sample_valid = 1'b0;
      chk("ready_oe", 8'h01, {7'h00, ready_n_oe});
      r(8'h12);
      u_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
      chk("ready_clear", 8'h00, {7'h00, ready_n_oe});
   endtask : sense
   task end_of_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // ==========================================================
   // Read answers are matched against the oldest note.
   always @(negedge clk_sys) if (reg_rvalid === 1'b1) begin
      m = exp_q.size() ? exp_q.pop_front() : 16'hFFFF;
      chk($sformatf("reg %h", m[15:8]), m[7:0], reg_rdata);
   end
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      end_of_test;
   end
   initial begin
      {rstn, sample_valid, sample, seed} = {1'b0, 1'b0, 64'h0, 32'd1025};
      sh = '{default: 8'h00};
      for (c = 0; c < 2; c++) begin
         sh[8'h40 + c] = tpd_pkg::RST_CONFIG;
         sh[8'h50 + 2 * c] = tpd_pkg::RST_NEAR_THR;
         sh[8'h51 + 2 * c] = tpd_pkg::RST_TOUCH_THR;
      end
      repeat (6) @(negedge clk_sys);
      rstn = 1'b1;
      for (t = 0; t < 2; t++) begin
         for (i = 0; i < 12; i++) r(i < 11 ? regs[i] : 8'h77);
         for (i = 1; i < 11; i++) w(regs[i], 8'($random(seed)));
         w(8'h12, 8'hFF);
      end
      w(8'h43, 8'h21);
      w(8'h45, 8'h01);
      w(8'h42, 8'h01);
      for (i = 0; i < 80; i++) begin
         w(8'h40, 8'($random(seed)) & 8'h03);
         w(8'h41, 8'($random(seed)) & 8'h03);
         w(8'h50 + 8'(i % 4), 8'($random(seed)) & (i[0] ? 8'h03 : 8'hFF));
         bs[0] = 16'h0400 | 16'($random(seed) & 32'h7FFF);
         bs[1] = 16'h0400 | 16'($random(seed) & 32'h7FFF);
         ad = (i < 8) ? {8'h00, sh[8'h50]} + 16'(i[1]) : 16'($random(seed) & 32'h1FF);
         sense();
      end
      u_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
      for (t = 0; t < 20 && exp_q.size() > 0; t++) @(negedge clk_sys);
      if (exp_q.size() > 0) mismatches++;
      end_of_test;
   end
endmodule : test_dual_channel_touch_prox_detect
`default_nettype wire
